// ==== bench/mic_port_properties.sv ====
// checker of the command port between the host end and the device end
`timescale 1ns/10ps
module mic_port_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cmd_sel,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic irq
);
  logic rd_d_r;
  logic idle_r;
  logic odd_r;
  logic mask_seen_r;
  logic [7:0] since_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ****************
  // helper state
  // ****************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_d_r <= 1'b0;
      idle_r <= 1'b0;
      odd_r <= 1'b0;
      mask_seen_r <= 1'b0;
      since_r <= 8'hff;
    end else begin
      rd_d_r <= rd_stb && cmd_sel;
      if (wr_stb && (cmd_sel || odd_r))
        idle_r <= 1'b0;
      else if (rd_d_r)
        idle_r <= !rdata[0];
      if (wr_stb && !cmd_sel)
        odd_r <= !odd_r;
      if (wr_stb && cmd_sel && wdata == 8'h1c)
        mask_seen_r <= 1'b1;
      if (wr_stb && cmd_sel)
        since_r <= 8'h00;
      else if (since_r != 8'hff)
        since_r <= since_r + 8'h01;
    end
  end
  chk_strobes_apart: assert property (!(wr_stb && rd_stb))
    else $error("write and read strobes together");
  chk_write_after_idle: assert property (wr_stb && (cmd_sel || !odd_r) |-> idle_r)
    else $error("write without a poll that showed idle");
  chk_word_pairs: assert property (wr_stb && !cmd_sel && !odd_r |=> wr_stb && !cmd_sel)
    else $error("high data byte not followed by low byte");
  chk_busy_after_cmd: assert property (rd_stb && cmd_sel && since_r < 8'd15 |=> rdata[0])
    else $error("busy low too soon after a command");
  chk_masked_quiet: assert property (!mask_seen_r |-> !irq)
    else $error("interrupt while all conditions masked");
  chk_reset_quiet: assert property ($fell(reset) |-> !irq && rdata == 8'h00)
    else $error("port not quiet after reset");
  chk_status_hold: assert property (!(rd_stb && cmd_sel) |=> $stable(rdata))
    else $error("status byte changed without a read");
  chk_irq_has_flag: assert property (rd_d_r && $past(irq, 2) |-> rdata[6:1] != 6'h00)
    else $error("interrupt with no condition flag");
  chk_bit7_zero: assert property (rd_d_r |-> !rdata[7])
    else $error("unused status bit set");
endmodule

// ==== bench/motion_init_interrupt_commands_test.sv ====
// self-checking bench joining the host end and the device end
`timescale 1ns/10ps
module motion_init_interrupt_commands_test;
  typedef struct packed {logic [7:0] c; logic [2:0] n; logic [31:0] d; logic w; logic r;} mic_row_t;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic [31:0] raw_pos = 32'h100;
  logic [31:0] new_target = 32'h400;
  logic signed [15:0] pos_err = 16'h0000;
  logic enc_a = 1'b1;
  logic enc_b = 1'b1;
  logic enc_index = 1'b0;
  logic wrap_evt = 1'b0;
  logic traj_done_evt = 1'b0;
  logic [11:0] filter_drive = 12'hab0;
  logic wide_dac_fitted = 1'b0;
  logic req_valid = 1'b0;
  logic [7:0] req_code = 8'h00;
  logic [2:0] req_nbytes = 3'h0;
  logic [31:0] req_data = 32'h0;
  logic [31:0] cur_target = 32'h0;
  logic stat_req = 1'b0;
  logic [31:0] abs_pos, stop_target_raw, index_pos;
  logic wide_port, start_pulse, req_ready, req_done, req_refused, host_irq;
  logic [11:0] motor_code;
  logic [7:0] status;
  logic got_ref;
  logic start_seen = 1'b0;
  int err_count = 0;
  int total_checks = 0;
  mic_row_t rows [7] = '{
    '{8'h05, 3'h0, 32'h0, 1'b0, 1'b0},
    '{8'h06, 3'h0, 32'h0, 1'b0, 1'b1},
    '{8'h02, 3'h0, 32'h0, 1'b0, 1'b0},
    '{8'h1b, 3'h2, 32'h10, 1'b0, 1'b0},
    '{8'h1c, 3'h2, 32'hff84, 1'b0, 1'b0},
    '{8'h21, 3'h4, 32'h40000000, 1'b0, 1'b1},
    '{8'h21, 3'h4, 32'h900, 1'b0, 1'b0}
  };
  mic_if bus ();
  always #5 ref_clk = ~ref_clk;
  // start pulse is combinational, so it is caught away from the rising edge
  always @(negedge ref_clk) begin
    if (start_pulse) begin
      start_seen <= 1'b1;
    end
  end
  mic_device mic_device_inst (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .port(bus.dev),
    .raw_pos(raw_pos), .new_target(new_target), .pos_err(pos_err), .enc_a(enc_a), .enc_b(enc_b),
    .enc_index(enc_index), .wrap_evt(wrap_evt), .traj_done_evt(traj_done_evt),
    .filter_drive(filter_drive), .abs_pos(abs_pos), .stop_target_raw(stop_target_raw),
    .index_pos(index_pos), .wide_port(wide_port), .motor_code(motor_code),
    .start_pulse(start_pulse));
  mic_host mic_host_inst (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .port(bus.host),
    .wide_dac_fitted(wide_dac_fitted), .req_valid(req_valid), .req_code(req_code),
    .req_nbytes(req_nbytes), .req_data(req_data), .cur_target(cur_target), .stat_req(stat_req),
    .req_ready(req_ready), .req_done(req_done), .req_refused(req_refused), .status(status),
    .host_irq(host_irq));
  mic_port_chk mic_port_chk_inst (.ref_clk(ref_clk), .reset(reset), .cmd_sel(bus.cmd_sel),
    .wr_stb(bus.wr_stb), .rd_stb(bus.rd_stb), .wdata(bus.wdata), .rdata(bus.rdata), .irq(bus.irq));
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic do_req(input logic [7:0] c, input logic [2:0] n, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_code <= c;
    req_nbytes <= n;
    req_data <= d;
    do @(posedge ref_clk); while (!req_ready && k++ < 600);
    req_valid <= 1'b0;
    do begin
      @(negedge ref_clk);
      got_ref = req_refused;
    end while (!req_done && !req_refused && k++ < 1200);
    if (!req_done && !req_refused) begin
      err_count++;
      $display("[ERR] t=%0t request timed out code=%h", $time, c);
    end
  endtask
  // status compared with the busy bit left out
  task automatic read_stat(input logic [7:0] exp);
    int k;
    k = 0;
    @(posedge ref_clk);
    stat_req <= 1'b1;
    @(posedge ref_clk);
    stat_req <= 1'b0;
    cyc(8);
    do @(negedge ref_clk); while (!req_ready && k++ < 100);
    if (!req_ready) begin
      err_count++;
    end
    chk({status[7:1], 1'b0}, exp);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    cyc(20000);
    err_count++;
    end_of_test;
  end
  initial begin
    cyc(20);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk(motor_code, 12'h080);
    chk(wide_port, 1'b0);
    @(posedge ref_clk);
    traj_done_evt <= 1'b1;
    @(posedge ref_clk);
    traj_done_evt <= 1'b0;
    read_stat(8'h04);
    chk(host_irq, 1'b0);
    foreach (rows[i]) begin
      do_req(rows[i].c, rows[i].n, rows[i].d);
      chk(got_ref, rows[i].r);
      chk(wide_port, rows[i].w);
    end
    chk(host_irq, 1'b1);
    chk(abs_pos, 32'h0);
    @(posedge ref_clk);
    pos_err <= 16'h0010;
    wrap_evt <= 1'b1;
    @(posedge ref_clk);
    wrap_evt <= 1'b0;
    read_stat(8'h14);
    @(posedge ref_clk);
    pos_err <= 16'hffef;
    read_stat(8'h34);
    chk(motor_code, 12'h0ab);
    do_req(8'h1a, 3'h2, 32'h10);
    cyc(2);
    chk(motor_code, 12'h080);
    @(posedge ref_clk);
    pos_err <= 16'h0000;
    do_req(8'h1d, 3'h2, 32'h0);
    read_stat(8'h00);
    chk(host_irq, 1'b0);
    do_req(8'h03, 3'h0, 32'h0);
    @(posedge ref_clk);
    raw_pos <= 32'h150;
    enc_index <= 1'b1;
    cyc(3);
    raw_pos <= 32'h160;
    enc_a <= 1'b0;
    enc_b <= 1'b0;
    enc_index <= 1'b0;
    cyc(3);
    chk(index_pos, 32'h60);
    read_stat(8'h08);
    do_req(8'h20, 3'h4, 32'h70);
    @(posedge ref_clk);
    raw_pos <= 32'h170;
    read_stat(8'h48);
    chk(host_irq, 1'b0);
    @(posedge ref_clk);
    wide_dac_fitted <= 1'b1;
    do_req(8'h06, 3'h0, 32'h0);
    chk(wide_port, 1'b1);
    chk(motor_code, 12'h800);
    do_req(8'h05, 3'h0, 32'h0);
    chk(got_ref, 1'b1);
    do_req(8'h01, 3'h0, 32'h0);
    chk(motor_code, 12'hab0);
    chk(start_seen, 1'b1);
    chk(stop_target_raw, 32'h500);
    do_req(8'h02, 3'h0, 32'h0);
    chk(stop_target_raw, 32'h500);
    // a frozen device must miss an event raised while the enable is low
    @(posedge ref_clk);
    clk_en <= 1'b0;
    traj_done_evt <= 1'b1;
    cyc(2);
    traj_done_evt <= 1'b0;
    clk_en <= 1'b1;
    read_stat(8'h48);
    @(posedge ref_clk);
    wide_dac_fitted <= 1'b0;
    reset <= 1'b1;
    cyc(2);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk(wide_port, 1'b0);
    chk(motor_code, 12'h080);
    // software reset with a wide converter: the host follows with wide select
    @(posedge ref_clk);
    wide_dac_fitted <= 1'b1;
    do_req(8'h00, 3'h0, 32'h0);
    chk(req_ready, 1'b0);
    cyc(60);
    chk(wide_port, 1'b1);
    chk(req_ready, 1'b1);
    end_of_test;
  end
endmodule

// ==== common/mic_if.sv ====
// command port between the host end and the device end
`timescale 1ns/10ps
interface mic_if;
  logic cmd_sel;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic irq;
  modport dev (input cmd_sel, input wr_stb, input rd_stb, input wdata, output rdata, output irq);
  modport host (output cmd_sel, output wr_stb, output rd_stb, output wdata, input rdata, input irq);
endinterface

// ==== common/mic_params.svh ====
// constants for the motion command interpreter, shared by both ends
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH
`define MIC_CMD_START 8'h01
`define MIC_CMD_HOME 8'h02
`define MIC_CMD_INDEX 8'h03
`define MIC_CMD_NARROW 8'h05
`define MIC_CMD_WIDE 8'h06
`define MIC_CMD_ERR_STOP 8'h1a
`define MIC_CMD_ERR_ALARM 8'h1b
`define MIC_CMD_MASK 8'h1c
`define MIC_CMD_CLEAR 8'h1d
`define MIC_CMD_BP_ABS 8'h20
`define MIC_CMD_BP_REL 8'h21
`define MIC_CMD_RESET 8'h00
`define MIC_ST_BUSY 0
`define MIC_ST_CMDERR 1
`define MIC_ST_TRAJ 2
`define MIC_ST_INDEX 3
`define MIC_ST_WRAP 4
`define MIC_ST_POSERR 5
`define MIC_ST_BREAK 6
`define MIC_MASK_RESET 7'h00
`define MIC_ZERO_NARROW 12'h080
`define MIC_ZERO_WIDE 12'h800
`define MIC_CLK_NS 10
`define MIC_BUSY_NS 200
`define MIC_BUSY_CYC ((`MIC_BUSY_NS + `MIC_CLK_NS - 1) / `MIC_CLK_NS)
`endif

// ==== common/mic_pkg.sv ====
// types of the motion command interpreter
package mic_pkg;
  typedef struct packed {
    logic [7:0] busy_cnt;
    logic busy;
    logic [7:0] code;
    logic [2:0] left;
    logic [31:0] acc;
    logic wide;
    logic stop_mode;
    logic stop_act;
    logic [14:0] thr;
    logic [31:0] home_off;
    logic [31:0] stop_raw;
    logic [31:0] bp;
    logic bp_arm;
    logic idx_arm;
    logic idx_seen;
    logic [31:0] idx_pos;
    logic [6:0] flags;
    logic [6:0] mask;
    logic [7:0] rdata;
    logic [11:0] motor;
    logic irq;
  } mic_dev_t;

  typedef enum logic [7:0] {
    MIC_H_IDLE = 8'h01,
    MIC_H_POLL = 8'h02,
    MIC_H_RDW = 8'h04,
    MIC_H_CHK = 8'h08,
    MIC_H_CMD = 8'h10,
    MIC_H_DHI = 8'h20,
    MIC_H_DLO = 8'h40,
    MIC_H_STAT = 8'h80
  } mic_hstate_t;

  typedef struct packed {
    mic_hstate_t st;
    logic data_phase;
    logic [7:0] code;
    logic [2:0] left;
    logic [31:0] data;
    logic follow_wide;
    logic [7:0] stat;
    logic cmd_sel;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic done;
    logic refused;
  } mic_host_t;
endpackage

// ==== verilog/mic_device.sv ====
// device end: decodes and executes initialization and interrupt commands
//
// Behaviour
// - code 05 selects narrow output, default
// - host never selects narrow with wide converter
// - code 06 selects multiplexed wide output
// - host reissues wide select early, after a reset command (code 00)
// - host never selects wide on narrow systems
// - code 02 makes current position zero
// - home change keeps stop position until start
// - interrupt only for unmasked conditions
// - status shows flags regardless of mask
// - code 03 captures next index, sets bit3
// - capture when both phases and index low
// - code 1B loads two-byte error threshold
// - bit5 when error magnitude exceeds threshold
// - code 1A also forces motor to zero
// - code 20 absolute breakpoint sets bit6
// - code 21 breakpoint relative to target
// - host keeps relative breakpoint within range
// - code 1C bits 1-6 set masks
// - status bits 1-6 show six conditions
// - mask zero masks, other bits ignored
// - fixed bit positions of six conditions
// - data words high byte first, busy checked
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "mic_params.svh"
module mic_device (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  mic_if.dev port,
  input wire logic [31:0] raw_pos,
  input wire logic [31:0] new_target,
  input wire logic signed [15:0] pos_err,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_index,
  input wire logic wrap_evt,
  input wire logic traj_done_evt,
  input wire logic [11:0] filter_drive,
  output logic [31:0] abs_pos,
  output logic [31:0] stop_target_raw,
  output logic [31:0] index_pos,
  output logic wide_port,
  output logic [11:0] motor_code,
  output logic start_pulse
);
  mic_pkg::mic_dev_t r;
  mic_pkg::mic_dev_t n;

  // ****************************************
  // data byte count of each command
  // ****************************************
  function automatic logic [2:0] data_bytes(input logic [7:0] c);
    logic [2:0] b;
    b = 3'h0;
    unique case (c)
      `MIC_CMD_ERR_STOP, `MIC_CMD_ERR_ALARM, `MIC_CMD_MASK, `MIC_CMD_CLEAR: b = 3'h2;
      `MIC_CMD_BP_ABS, `MIC_CMD_BP_REL: b = 3'h4;
      default: b = 3'h0;
    endcase
    return b;
  endfunction

  logic [15:0] err_mag;
  logic [31:0] cur_abs;

  assign cur_abs = raw_pos - r.home_off;
  assign err_mag = pos_err[15] ? 16'(-pos_err) : 16'(pos_err);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic exec;
    logic [7:0] ecode;
    logic [31:0] edata;
    logic [6:0] set;
    logic [6:0] clr;
    logic [2:0] nb;
    exec = 1'b0;
    ecode = r.code;
    edata = r.acc;
    set = 7'h00;
    clr = 7'h00;
    nb = 3'h0;
    n = r;
    start_pulse = 1'b0;
    // busy timer
    if (r.busy) begin
      if (r.busy_cnt == 8'h01) begin
        n.busy = 1'b0;
      end
      n.busy_cnt = r.busy_cnt - 8'h01;
    end
    // command byte; not taken while busy, raises the command error flag instead
    if (port.cmd_sel && port.wr_stb) begin
      if (r.busy) begin
        set[`MIC_ST_CMDERR] = 1'b1;
      end else begin
        nb = data_bytes(port.wdata);
        n.code = port.wdata;
        n.left = nb;
        n.busy = 1'b1;
        n.busy_cnt = 8'(`MIC_BUSY_CYC);
        if (nb == 3'h0) begin
          exec = 1'b1;
          ecode = port.wdata;
        end
      end
    end
    // data bytes, more significant first; busy after each word
    if (!port.cmd_sel && port.wr_stb) begin
      if (r.left == 3'h0 || (r.busy && !r.left[0])) begin
        set[`MIC_ST_CMDERR] = 1'b1;
      end else begin
        n.acc = {r.acc[23:0], port.wdata};
        edata = {r.acc[23:0], port.wdata};
        n.left = r.left - 3'h1;
        if (r.left[0]) begin
          n.busy = 1'b1;
          n.busy_cnt = 8'(`MIC_BUSY_CYC);
        end
        if (r.left == 3'h1) begin
          exec = 1'b1;
        end
      end
    end
    // execution
    if (exec) begin
      unique case (ecode)
        `MIC_CMD_NARROW: n.wide = 1'b0;
        `MIC_CMD_WIDE: n.wide = 1'b1;
        `MIC_CMD_HOME: n.home_off = raw_pos;
        `MIC_CMD_START: begin
          n.stop_raw = new_target + r.home_off;
          n.stop_act = 1'b0;
          start_pulse = 1'b1;
        end
        `MIC_CMD_INDEX: begin
          n.idx_arm = 1'b1;
          n.idx_seen = 1'b0;
        end
        `MIC_CMD_ERR_ALARM: begin
          n.thr = edata[14:0];
          n.stop_mode = 1'b0;
        end
        `MIC_CMD_ERR_STOP: begin
          n.thr = edata[14:0];
          n.stop_mode = 1'b1;
        end
        `MIC_CMD_BP_ABS: begin
          n.bp = edata;
          n.bp_arm = 1'b1;
        end
        `MIC_CMD_BP_REL: begin
          n.bp = edata + (r.stop_raw - r.home_off);
          n.bp_arm = 1'b1;
        end
        `MIC_CMD_MASK: n.mask = {edata[6:1], 1'b0};
        `MIC_CMD_CLEAR: clr = {~edata[6:1], 1'b0};
        default: set[`MIC_ST_CMDERR] = 1'b1;
      endcase
    end
    // index capture: after the pulse, at the all-low point
    if (r.idx_arm) begin
      if (enc_index) begin
        n.idx_seen = 1'b1;
      end
      if (r.idx_seen && !enc_a && !enc_b && !enc_index) begin
        n.idx_pos = cur_abs;
        n.idx_arm = 1'b0;
        set[`MIC_ST_INDEX] = 1'b1;
      end
    end
    // position error
    if (err_mag > {1'b0, r.thr}) begin
      set[`MIC_ST_POSERR] = 1'b1;
      if (r.stop_mode) begin
        n.stop_act = 1'b1;
      end
    end
    // breakpoint
    if (r.bp_arm && cur_abs == r.bp) begin
      set[`MIC_ST_BREAK] = 1'b1;
      n.bp_arm = 1'b0;
    end
    set[`MIC_ST_WRAP] = set[`MIC_ST_WRAP] | wrap_evt;
    set[`MIC_ST_TRAJ] = set[`MIC_ST_TRAJ] | traj_done_evt;
    // new events win over a clear in the same cycle
    n.flags = ((r.flags & ~clr) | set) & 7'h7e;
    n.irq = |(n.flags & n.mask);
    if (port.cmd_sel && port.rd_stb) begin
      n.rdata = {1'b0, r.flags[6:1], r.busy};
    end
    if (n.stop_act) begin
      n.motor = n.wide ? `MIC_ZERO_WIDE : `MIC_ZERO_NARROW;
    end else begin
      n.motor = n.wide ? filter_drive : {4'h0, filter_drive[11:4]};
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r <= '0;
      r.mask <= `MIC_MASK_RESET;
      r.motor <= `MIC_ZERO_NARROW;
    end else if (clk_en) begin
      r <= n;
    end
  end

  assign port.rdata = r.rdata;
  assign port.irq = r.irq;
  assign abs_pos = cur_abs;
  assign stop_target_raw = r.stop_raw;
  assign index_pos = r.idx_pos;
  assign wide_port = r.wide;
  assign motor_code = r.motor;
endmodule

// ==== verilog/mic_host.sv ====
// host end: polls busy and writes commands with their data words
`timescale 1ns/10ps
`include "mic_params.svh"
module mic_host (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  mic_if.host port,
  input wire logic wide_dac_fitted,
  input wire logic req_valid,
  input wire logic [7:0] req_code,
  input wire logic [2:0] req_nbytes,
  input wire logic [31:0] req_data,
  input wire logic [31:0] cur_target,
  input wire logic stat_req,
  output logic req_ready,
  output logic req_done,
  output logic req_refused,
  output logic [7:0] status,
  output logic host_irq
);
  mic_pkg::mic_host_t r;
  mic_pkg::mic_host_t n;

  logic [32:0] bp_sum;
  logic bad;

  assign bp_sum = {cur_target[31], cur_target} + {req_data[31], req_data};

  // ****************************************
  // request screening
  // ****************************************
  always_comb begin
    bad = 1'b0;
    if (req_code == `MIC_CMD_NARROW && wide_dac_fitted) begin
      bad = 1'b1;
    end
    if (req_code == `MIC_CMD_WIDE && !wide_dac_fitted) begin
      bad = 1'b1;
    end
    if (req_code == `MIC_CMD_BP_REL && !(bp_sum[32] == bp_sum[31] && bp_sum[31] == bp_sum[30])) begin
      bad = 1'b1;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    n = r;
    n.wr = 1'b0;
    n.rd = 1'b0;
    n.done = 1'b0;
    n.refused = 1'b0;
    unique case (r.st)
      mic_pkg::MIC_H_IDLE: begin
        if (r.follow_wide) begin
          n.follow_wide = 1'b0;
          n.code = `MIC_CMD_WIDE;
          n.left = 3'h0;
          n.data_phase = 1'b0;
          n.st = mic_pkg::MIC_H_POLL;
        end else if (req_valid && bad) begin
          n.refused = 1'b1;
        end else if (req_valid) begin
          n.code = req_code;
          n.left = req_nbytes;
          n.data = req_data << {(3'h4 - req_nbytes), 3'h0};
          n.data_phase = 1'b0;
          n.follow_wide = (req_code == `MIC_CMD_RESET) && wide_dac_fitted;
          n.st = mic_pkg::MIC_H_POLL;
        end else if (stat_req) begin
          n.cmd_sel = 1'b1;
          n.rd = 1'b1;
          n.st = mic_pkg::MIC_H_STAT;
        end
      end
      mic_pkg::MIC_H_POLL: begin
        n.cmd_sel = 1'b1;
        n.rd = 1'b1;
        n.st = mic_pkg::MIC_H_RDW;
      end
      mic_pkg::MIC_H_RDW: n.st = mic_pkg::MIC_H_CHK;
      mic_pkg::MIC_H_CHK: begin
        n.stat = port.rdata;
        if (port.rdata[`MIC_ST_BUSY]) begin
          n.st = mic_pkg::MIC_H_POLL;
        end else if (!r.data_phase) begin
          n.cmd_sel = 1'b1;
          n.wr = 1'b1;
          n.wdata = r.code;
          n.st = mic_pkg::MIC_H_CMD;
        end else begin
          n.cmd_sel = 1'b0;
          n.wr = 1'b1;
          n.wdata = r.data[31:24];
          n.data = {r.data[23:0], 8'h00};
          n.st = mic_pkg::MIC_H_DHI;
        end
      end
      mic_pkg::MIC_H_CMD: begin
        n.data_phase = 1'b1;
        if (r.left == 3'h0) begin
          n.done = 1'b1;
          n.st = mic_pkg::MIC_H_IDLE;
        end else begin
          n.st = mic_pkg::MIC_H_POLL;
        end
      end
      mic_pkg::MIC_H_DHI: begin
        n.wr = 1'b1;
        n.wdata = r.data[31:24];
        n.data = {r.data[23:0], 8'h00};
        n.left = r.left - 3'h2;
        n.st = mic_pkg::MIC_H_DLO;
      end
      mic_pkg::MIC_H_DLO: begin
        if (r.left == 3'h0) begin
          n.done = 1'b1;
          n.st = mic_pkg::MIC_H_IDLE;
        end else begin
          n.st = mic_pkg::MIC_H_POLL;
        end
      end
      // a plain status read waits out the strobe cycle, then takes the byte
      mic_pkg::MIC_H_STAT: begin
        if (!r.rd) begin
          n.stat = port.rdata;
          n.st = mic_pkg::MIC_H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r <= '0;
      r.st <= mic_pkg::MIC_H_IDLE;
      r.code <= 8'h00;
    end else if (clk_en) begin
      r <= n;
    end
  end

  assign port.cmd_sel = r.cmd_sel;
  assign port.wr_stb = r.wr;
  assign port.rd_stb = r.rd;
  assign port.wdata = r.wdata;
  assign req_ready = (r.st == mic_pkg::MIC_H_IDLE) && !r.follow_wide;
  assign req_done = r.done;
  assign req_refused = r.refused;
  assign status = r.stat;
  assign host_irq = port.irq;
endmodule
